// ===== hw/sst_regs.vh
`ifndef SST_REGS_VH
`define SST_REGS_VH

// Register byte offsets on the plain register port.
`define SST_OFF_IDLE_RELOAD   8'ha8
`define SST_OFF_CAUSE         8'haa
`define SST_OFF_THROTTLE_LOW  8'hac
`define SST_OFF_THROTTLE_HIGH 8'hae

// Reset values.
`define SST_RST_IDLE_RELOAD   8'h0f
`define SST_RST_CAUSE         8'h00
`define SST_RST_THROTTLE_LOW  8'h00
`define SST_RST_THROTTLE_HIGH 8'h00

// Cause register field positions.
`define SST_CAUSE_PORT_WRITE  7
`define SST_CAUSE_EXTERNAL    6
`define SST_CAUSE_IDLE        5
`define SST_CAUSE_LINES_MSB   4
`define SST_CAUSE_LINES_LSB   0
`define SST_CAUSE_WIDTH       8
`define SST_NUM_LINES         5

// Timing: clock rate, throttle time base and idle countdown interval.
`define SST_CLK_MHZ           100
`define SST_THR_TICK_US       32
`define SST_THR_TICK_CYCLES   12'd3200
`define SST_THR_TICK_W        12
`define SST_IDLE_TICK_S       60
`define SST_IDLE_TICK_CYCLES  (33'd60 * 33'd100000000)
`define SST_IDLE_TICK_W       33

`endif

// ===== hw/sst_tick.v
`timescale 1ns/1ps
// Divider that emits a one-cycle pulse every DIV clocks while run is high.
module sst_tick #(
   parameter         W   = 12,
   parameter [W-1:0] DIV = 3200
) (
   input  wire clk,
   input  wire srst,
   input  wire run,
   output reg  tick
);
   reg [W-1:0] count;

   // Counts up to DIV-1 and restarts; held at zero while stopped.
   always @(posedge clk) begin
      if (srst || !run) begin
         count <= {W{1'b0}};
         tick  <= 1'b0;
      end else if (count == DIV - 1'b1) begin
         count <= {W{1'b0}};
         tick  <= 1'b1;
      end else begin
         count <= count + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule

// ===== hw/sst_throttle.v
`timescale 1ns/1ps
`include "sst_regs.vh"
// Throttle sequencer: alternates the stop-clock output between low and high periods.
module sst_throttle (
   input  wire       clk,
   input  wire       srst,
   input  wire       enable,
   input  wire       tick,
   input  wire       stop_grant,
   input  wire [7:0] low_period,
   input  wire [7:0] high_period,
   output reg        stop_clock_out_n
);
   reg [1:0] state;
   reg [7:0] timer;
   wire      phase_end;

   // Sequencer states.
   localparam [1:0] THR_OFF   = 2'd0;
   localparam [1:0] THR_GRANT = 2'd1;
   localparam [1:0] THR_LOW   = 2'd2;
   localparam [1:0] THR_HIGH  = 2'd3;

   // A phase ends on the tick that takes the timer to zero, or on the next tick if it was zero.
   assign phase_end = tick && (timer <= 8'h01);

   // Sequencer; disabling throttling negates stop-clock at once.
   always @(posedge clk) begin
      if (srst || !enable) begin
         state            <= THR_OFF;
         timer            <= 8'h00;
         stop_clock_out_n <= 1'b1;
      end else begin
         case (state)
            THR_OFF: begin
               state            <= THR_GRANT;
               timer            <= low_period;
               stop_clock_out_n <= 1'b0;
            end
            THR_GRANT: begin
               // Timer is held until the processor returns its stop-grant cycle.
               if (stop_grant) begin
                  state <= THR_LOW;
               end
            end
            THR_LOW: begin
               if (phase_end) begin
                  state            <= THR_HIGH;
                  timer            <= high_period;
                  stop_clock_out_n <= 1'b1;
               end else if (tick) begin
                  timer <= timer - 1'b1;
               end
            end
            default: begin
               if (phase_end) begin
                  state            <= THR_GRANT;
                  timer            <= low_period;
                  stop_clock_out_n <= 1'b0;
               end else if (tick) begin
                  timer <= timer - 1'b1;
               end
            end
         endcase
      end
   end
endmodule

// ===== hw/sst_top.v
`timescale 1ns/1ps
`include "sst_regs.vh"
module sst_top #(
   parameter [`SST_IDLE_TICK_W-1:0] IDLE_TICK_CYCLES = `SST_IDLE_TICK_CYCLES
) (
   input  wire                      clk,
   input  wire                      srst,
   input  wire [7:0]                reg_addr,
   input  wire [15:0]               reg_wdata,
   input  wire                      reg_wr,
   input  wire                      reg_rd,
   output reg  [15:0]               reg_rdata,
   input  wire                      mgmt_interrupt_gate,
   input  wire                      throttle_enable,
   input  wire                      idle_stop,
   input  wire [`SST_CAUSE_WIDTH-1:0] event_enable,
   input  wire                      system_event,
   input  wire                      power_port_write,
   input  wire                      external_mgmt_request_in_n,
   input  wire [`SST_NUM_LINES-1:0] irq_line,
   input  wire                      stop_grant,
   output wire                      stop_clock_out_n,
   output reg                       mgmt_interrupt_out_n
);
   // Registers written by software.
   reg  [7:0]                   idle_countdown_reload;
   reg  [7:0]                   throttle_low_period;
   reg  [7:0]                   throttle_high_period;
   reg  [`SST_CAUSE_WIDTH-1:0]  smi_cause_status;

   // Event detection state.
   reg  [`SST_NUM_LINES-1:0]    irq_line_prev;
   reg                          external_prev;
   wire [`SST_NUM_LINES-1:0]    line_rise;
   wire                         external_fall;
   wire [`SST_CAUSE_WIDTH-1:0]  raw_event;
   wire [`SST_CAUSE_WIDTH-1:0]  set_vec;
   wire [`SST_CAUSE_WIDTH-1:0]  clear_vec;
   reg  [`SST_CAUSE_WIDTH-1:0]  next_cause;

   // Idle countdown state.
   reg  [7:0]                   idle_count;
   reg                          idle_expire;
   wire                         idle_tick;
   wire                         thr_tick;

   // Register decode.
   wire                         wr_cause;
   wire                         wr_idle;
   wire                         wr_low;
   wire                         wr_high;

   genvar                       i;

   // Write strobes per register.
   assign wr_cause = reg_wr && (reg_addr == `SST_OFF_CAUSE);
   assign wr_idle  = reg_wr && (reg_addr == `SST_OFF_IDLE_RELOAD);
   assign wr_low   = reg_wr && (reg_addr == `SST_OFF_THROTTLE_LOW);
   assign wr_high  = reg_wr && (reg_addr == `SST_OFF_THROTTLE_HIGH);

   // Plain read-write registers; the idle reload reads back the low byte of what was written, upper byte zero.
   always @(posedge clk) begin
      if (srst) begin
         idle_countdown_reload <= `SST_RST_IDLE_RELOAD;
         throttle_low_period   <= `SST_RST_THROTTLE_LOW;
         throttle_high_period  <= `SST_RST_THROTTLE_HIGH;
      end else begin
         if (wr_idle) begin
            idle_countdown_reload <= reg_wdata[7:0];
         end
         if (wr_low) begin
            throttle_low_period <= reg_wdata[7:0];
         end
         if (wr_high) begin
            throttle_high_period <= reg_wdata[7:0];
         end
      end
   end

   // Previous levels of the event inputs, for edge detection.
   always @(posedge clk) begin
      if (srst) begin
         irq_line_prev <= {`SST_NUM_LINES{1'b0}};
         external_prev <= 1'b1;
      end else begin
         irq_line_prev <= irq_line;
         external_prev <= external_mgmt_request_in_n;
      end
   end

   // Only asserting edges count, so a line held active yields one indication.
   assign line_rise     = irq_line & ~irq_line_prev;
   assign external_fall = external_prev & ~external_mgmt_request_in_n;

   // Raw event vector in cause-bit order.
   assign raw_event[`SST_CAUSE_PORT_WRITE] = power_port_write;
   assign raw_event[`SST_CAUSE_EXTERNAL]   = external_fall;
   assign raw_event[`SST_CAUSE_IDLE]       = idle_expire;
   assign raw_event[`SST_CAUSE_LINES_MSB:`SST_CAUSE_LINES_LSB] = line_rise;

   // Per-bit set and clear terms; each bit stands alone.
   generate
      for (i = 0; i < `SST_CAUSE_WIDTH; i = i + 1) begin : g_cause
         assign set_vec[i]   = raw_event[i] && event_enable[i];
         assign clear_vec[i] = wr_cause && !reg_wdata[i];
      end
   endgenerate

   // Clear first, then set, so a coincident set wins.
   always @* begin
      next_cause = (smi_cause_status & ~clear_vec) | set_vec;
   end

   // Cause register; the gate does not take part here.
   always @(posedge clk) begin
      if (srst) begin
         smi_cause_status <= `SST_RST_CAUSE;
      end else begin
         smi_cause_status <= next_cause;
      end
   end

   // Interrupt pin, active low, asserted while any cause is pending and the gate is open.
   always @(posedge clk) begin
      if (srst) begin
         mgmt_interrupt_out_n <= 1'b1;
      end else begin
         mgmt_interrupt_out_n <= !(mgmt_interrupt_gate && (|smi_cause_status));
      end
   end

   // One-minute time base for the idle countdown, held while it is stopped.
   sst_tick #(
      .W   (`SST_IDLE_TICK_W),
      .DIV (IDLE_TICK_CYCLES)
   ) u_idle_tick (
      .clk  (clk),
      .srst (srst),
      .run  (!idle_stop),
      .tick (idle_tick)
   );

   // Idle countdown: reload on system events, step each minute, expire at zero.
   always @(posedge clk) begin
      if (srst) begin
         idle_count  <= `SST_RST_IDLE_RELOAD;
         idle_expire <= 1'b0;
      end else if (idle_stop) begin
         idle_expire <= 1'b0;
      end else if (idle_expire) begin
         idle_count  <= idle_countdown_reload;
         idle_expire <= 1'b0;
      end else if (system_event) begin
         idle_count <= idle_countdown_reload;
      end else if (idle_count == 8'h00) begin
         idle_expire <= 1'b1;
      end else if (idle_tick) begin
         idle_count <= idle_count - 1'b1;
      end
   end

   // Free-running 32 us time base for the throttle timer.
   sst_tick #(
      .W   (`SST_THR_TICK_W),
      .DIV (`SST_THR_TICK_CYCLES)
   ) u_thr_tick (
      .clk  (clk),
      .srst (srst),
      .run  (1'b1),
      .tick (thr_tick)
   );

   // Stop-clock throttle sequencer.
   sst_throttle u_throttle (
      .clk              (clk),
      .srst             (srst),
      .enable           (throttle_enable),
      .tick             (thr_tick),
      .stop_grant       (stop_grant),
      .low_period       (throttle_low_period),
      .high_period      (throttle_high_period),
      .stop_clock_out_n (stop_clock_out_n)
   );

   // Read data, valid the cycle after the read strobe; unmapped reads return zero.
   always @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         if (reg_addr == `SST_OFF_CAUSE) begin
            reg_rdata <= {8'h00, smi_cause_status};
         end else if (reg_addr == `SST_OFF_IDLE_RELOAD) begin
            reg_rdata <= {8'h00, idle_countdown_reload};
         end else if (reg_addr == `SST_OFF_THROTTLE_LOW) begin
            reg_rdata <= {8'h00, throttle_low_period};
         end else if (reg_addr == `SST_OFF_THROTTLE_HIGH) begin
            reg_rdata <= {8'h00, throttle_high_period};
         end else begin
            reg_rdata <= 16'h0000;
         end
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule

// ===== verif/sst_host_model.sv
`timescale 1ns/1ps
// Processor side: answers stop-clock assertion with one stop-grant pulse.
module sst_host_model (
   input  wire       clk,
   input  wire       srst,
   input  wire       stop_clock_out_n,
   input  wire [7:0] delay,
   output reg        stop_grant
);
   reg [8:0] cnt;
   reg       done;
   // Grant once per assertion, delay cycles late; a negated pin rearms it.
   always @(posedge clk) begin
      if (srst || stop_clock_out_n) begin
         cnt <= 9'h000;
         done <= 1'b0;
         stop_grant <= 1'b0;
      end else if (!done) begin
         cnt <= cnt + 9'h001;
         stop_grant <= (cnt == {1'b0, delay});
         done <= (cnt == {1'b0, delay});
      end else begin
         stop_grant <= 1'b0;
      end
   end
endmodule

// ===== verif/sst_top_assertions.sv
`timescale 1ns/1ps
// Port-level checker for the status and throttle block.
module sst_top_assertions (
   input wire        clk,
   input wire        srst,
   input wire [7:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   input wire        mgmt_interrupt_gate,
   input wire        throttle_enable,
   input wire [7:0]  event_enable,
   input wire        power_port_write,
   input wire [4:0]  irq_line,
   input wire        stop_grant,
   input wire        stop_clock_out_n,
   input wire        mgmt_interrupt_out_n
);
   localparam int TICK = 3200;
   reg        waiting;
   reg [19:0] hcnt;
   reg [7:0]  hp;
   // Track the grant wait, the negated phase length and the high period.
   always @(posedge clk) begin
      if (srst) begin
         waiting <= 1'b0;
         hcnt <= 20'h00000;
         hp <= 8'h00;
      end else begin
         waiting <= (stop_grant || !throttle_enable) ? 1'b0 :
                    ($fell(stop_clock_out_n) ? 1'b1 : waiting);
         hcnt <= (stop_clock_out_n && throttle_enable) ? hcnt + 20'h00001 : 20'h00000;
         if (reg_wr && reg_addr == 8'hae)
            hp <= reg_wdata[7:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_rsvd_zero: assert property ($past(reg_rd) |-> reg_rdata[15:8] == 8'h00)
      else $error("reserved read bits not zero");
   a_gate_mask: assert property (!mgmt_interrupt_gate |=> mgmt_interrupt_out_n)
      else $error("interrupt pin low with gate off");
   a_line_sets: assert property ($rose(irq_line[0]) && event_enable[0]
      && mgmt_interrupt_gate ##1 mgmt_interrupt_gate |=> !mgmt_interrupt_out_n)
      else $error("line edge gave no interrupt");
   a_port_sets: assert property (power_port_write && event_enable[7]
      && mgmt_interrupt_gate ##1 mgmt_interrupt_gate |=> !mgmt_interrupt_out_n)
      else $error("port write gave no interrupt");
   a_stop_off: assert property (!throttle_enable |=> stop_clock_out_n)
      else $error("stop clock asserted while disabled");
   a_stop_on: assert property ($rose(throttle_enable) |=> !stop_clock_out_n)
      else $error("stop clock not asserted on enable");
   a_grant_hold: assert property (waiting && throttle_enable |-> !stop_clock_out_n)
      else $error("stop clock released before grant");
   a_high_len: assert property ($fell(stop_clock_out_n) && hcnt > 20'd1
      |-> hcnt == TICK * ((hp == 8'h00) ? 1 : hp))
      else $error("negated phase length wrong");
   c_grant: cover property (stop_grant);
   c_irq: cover property ($fell(mgmt_interrupt_out_n));
   c_phase: cover property ($rose(stop_clock_out_n) && throttle_enable);
endmodule
bind sst_top sst_top_assertions u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mgmt_interrupt_gate(mgmt_interrupt_gate), .throttle_enable(throttle_enable),
   .event_enable(event_enable), .power_port_write(power_port_write), .irq_line(irq_line),
   .stop_grant(stop_grant), .stop_clock_out_n(stop_clock_out_n),
   .mgmt_interrupt_out_n(mgmt_interrupt_out_n));

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg         clk, srst, reg_wr, reg_rd, gate, thr_en, idle_stop, sys_ev, pw, ext_n;
   reg         rd_d = 1'b0;
   reg  [7:0]  reg_addr, ev_en, gdly;
   reg  [15:0] reg_wdata, acc, v;
   reg  [4:0]  irq;
   wire [15:0] reg_rdata;
   wire        stop_grant, stop_n, smi_n;
   reg  [15:0] expq[$];
   int         n_fail, n_compared, i, t;
   sst_top #(.IDLE_TICK_CYCLES(33'd20)) DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mgmt_interrupt_gate(gate), .throttle_enable(thr_en), .idle_stop(idle_stop),
      .event_enable(ev_en), .system_event(sys_ev), .power_port_write(pw),
      .external_mgmt_request_in_n(ext_n), .irq_line(irq), .stop_grant(stop_grant),
      .stop_clock_out_n(stop_n), .mgmt_interrupt_out_n(smi_n));
   sst_host_model u_host (.clk(clk), .srst(srst), .stop_clock_out_n(stop_n), .delay(gdly),
      .stop_grant(stop_grant));
   task chk(input string name, input logic [19:0] e, input logic [19:0] s);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, e, s);
      end
   endtask
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task wr(input [7:0] a, input [15:0] d);
      @(posedge clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk); reg_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, input [15:0] e);
      @(posedge clk); reg_rd <= 1'b1; reg_addr <= a; expq.push_back(e);
      @(posedge clk); reg_rd <= 1'b0;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Clock generator.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Read data stand one cycle after the strobe; compare with the oldest note.
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d) chk("reg_rdata", expq.pop_front(), reg_rdata);
   end
   // Cut a hang short.
   initial begin
      #400000;
      n_fail++;
      give_verdict;
   end
   // Main sequence.
   initial begin
      {reg_wr, reg_rd, gate, thr_en, sys_ev, pw, reg_addr, reg_wdata, ev_en, irq} = '0;
      srst = 1'b1; idle_stop = 1'b1; ext_n = 1'b1;
      t = $urandom(32'h3e10);
      gdly = 8'd2 + 8'($urandom % 40);
      cyc(2); srst <= 1'b0;
      rd(8'ha8, 16'h000f); rd(8'haa, 16'h0000); rd(8'hac, 16'h0000);
      rd(8'hae, 16'h0000); rd(8'h10, 16'h0000);
      wr(8'h10, 16'hffff); rd(8'h10, 16'h0000);
      for (i = 0; i < 3; i++) begin
         v = 16'($urandom) | 16'h0001;
         wr(8'ha8, v); rd(8'ha8, {8'h00, v[7:0]});
         wr(8'hac, ~v); rd(8'hac, {8'h00, ~v[7:0]});
         wr(8'hae, v); rd(8'hae, {8'h00, v[7:0]});
      end
      gate <= 1'b1; ev_en <= 8'hdf; acc = 16'h0000;
      for (i = 0; i < 5; i++) begin
         @(posedge clk); irq[i] <= 1'b1;
         cyc(2); acc[i] = 1'b1;
         rd(8'haa, acc);
      end
      @(posedge clk); pw <= 1'b1;
      @(posedge clk); pw <= 1'b0; ext_n <= 1'b0;
      cyc(2); rd(8'haa, 16'h00df);
      chk("irq_pin", 20'h0, {19'h0, smi_n});
      wr(8'haa, 16'hfffe); cyc(3); rd(8'haa, 16'h00de);
      gate <= 1'b0; irq <= 5'h00; ext_n <= 1'b1;
      wr(8'haa, 16'h0000); rd(8'haa, 16'h0000);
      ev_en <= 8'hdb;
      @(posedge clk); irq <= 5'h06; reg_wr <= 1'b1; reg_addr <= 8'haa; reg_wdata <= 16'h0;
      @(posedge clk); reg_wr <= 1'b0;
      rd(8'haa, 16'h0002);
      chk("irq_gated", 20'h1, {19'h0, smi_n});
      ev_en <= 8'h20; wr(8'ha8, 16'h0002); wr(8'haa, 16'h0000);
      sys_ev <= 1'b1; idle_stop <= 1'b0;
      cyc(200); rd(8'haa, 16'h0000);
      sys_ev <= 1'b0; cyc(100); rd(8'haa, 16'h0020);
      wr(8'haa, 16'h0000); cyc(100); rd(8'haa, 16'h0020);
      idle_stop <= 1'b1; cyc(3); wr(8'haa, 16'h0000); cyc(200);
      rd(8'haa, 16'h0000);
      wr(8'hae, 16'h0002); wr(8'hac, 16'h0003);
      @(posedge clk); thr_en <= 1'b1;
      cyc(2); chk("stop_asserted", 20'h0, {19'h0, stop_n});
      t = 0;
      while (stop_grant !== 1'b1 && t < 200) begin @(posedge clk); t++; end
      chk("grant_seen", 20'h1, {19'h0, stop_grant});
      t = 0;
      while (stop_n !== 1'b1 && t < 20000) begin @(posedge clk); t++; end
      chk("low_len_ok", 20'h1, {19'h0, (t > 6400 && t <= 9602)});
      t = 0;
      while (stop_n === 1'b1 && t < 20000) begin @(posedge clk); t++; end
      chk("high_len", 20'd6400, 20'(t));
      cyc(5); chk("stop_again", 20'h0, {19'h0, stop_n});
      thr_en <= 1'b0; cyc(2); chk("stop_off", 20'h1, {19'h0, stop_n});
      cyc(3);
      give_verdict;
   end
endmodule
